// >>> core/prxcfg_pkg.sv
package prxcfg_pkg;
  // Register byte addresses on the serial register port
  localparam logic [7:0] ADDR_PROX_RESULT = 8'h9c;
  localparam logic [7:0] ADDR_OFFSET_NE = 8'h9d;
  localparam logic [7:0] ADDR_OFFSET_SW = 8'h9e;
  localparam logic [7:0] ADDR_DIODE_CFG = 8'h9f;
  // Field positions in diode_select_config
  localparam int CFG_PAIR_GAIN_COMP = 5;
  localparam int CFG_SLEEP_AFTER_IRQ = 4;
  localparam int CFG_MASK_NORTH = 3;
  localparam int CFG_MASK_SOUTH = 2;
  localparam int CFG_MASK_WEST = 1;
  localparam int CFG_MASK_EAST = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h3f;
  // Values after reset
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  // Result limits
  localparam logic [7:0] HALF_SCALE = 8'h7f;
  localparam logic [7:0] FULL_SCALE = 8'hff;

  // Register access request from the serial front end
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } prxcfg_req_t;

  // Offset corrections and diode selection handed to the analog path
  typedef struct packed {
    logic [7:0] offset_ne;
    logic [7:0] offset_sw;
    logic [3:0] diode_en;
    logic pair_ne_en;
    logic pair_sw_en;
  } prxcfg_afe_t;

  // Sequencer states as seen around the sleep decision point
  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_DECIDE = 2'b01,
    SEQ_SLEEP = 2'b10
  } prxcfg_seq_t;
endpackage

// >>> core/prxcfg_gain.sv
`timescale 1ns/1ps
module prxcfg_gain (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw conversion and compensation enable
  input wire logic load_i,
  input wire logic [7:0] raw_i,
  input wire logic comp_i,
  // Stored result
  output logic [7:0] result_o
);
  import prxcfg_pkg::*;

  logic [8:0] doubled;

  // Double the raw code; the ninth bit flags overflow
  assign doubled = {raw_i, 1'b0};

  // Saturate instead of wrapping so a near-object never reads as far
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_o <= RST_RESULT;
    end else if (load_i) begin
      if (!comp_i) begin
        result_o <= raw_i;
      end else if (doubled[8]) begin
        result_o <= FULL_SCALE;
      end else begin
        result_o <= doubled[7:0];
      end
    end
  end
endmodule // prxcfg_gain

// >>> core/prxcfg_top.sv
`timescale 1ns/1ps
// What this block does
// - Proximity result readable as one 8-bit byte at 0x9C.
// - Reading the result byte clears the proximity-valid flag unless a conversion completes in the same cycle.
// - Writable 8-bit north/east crosstalk offset at 0x9D.
// - Writable 8-bit south/west crosstalk offset at 0x9E.
// - Offsets are sign/magnitude: top bit negative, seven magnitude bits.
// - North with east form one pair; south with west the other.
// - With one diode of a pair, result tops out at 127.
// - Gain compensation bit 5 doubles the result, saturating at 255; a one-diode result tops out at 254.
// - Sleep-after-interrupt bit 4 sleeps at decision point while irq high.
// - Host clears interrupt; device then resumes normal sequencing.
// - Mask bits N3, S2, W1, E0 set to 1 remove that diode.
module prxcfg_top (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // Register access from the serial front end
  input wire prxcfg_pkg::prxcfg_req_t REQ_I,
  output logic [7:0] RDATA_O,
  // Conversion result from the analog path
  input wire logic CONV_DONE_I,
  input wire logic [7:0] CONV_RAW_I,
  input wire logic HALF_RAW_I,
  // Sequencer hooks
  input wire logic SEQ_AT_DECISION_I,
  input wire logic IRQ_PIN_I,
  output logic SLEEP_O,
  // Analog settings and status
  output prxcfg_pkg::prxcfg_afe_t AFE_O,
  output logic PROX_RESULT_VALID_O
);
  import prxcfg_pkg::*;

  logic [7:0] offset_ne_q;
  logic [7:0] offset_sw_q;
  logic [7:0] cfg_q;
  logic valid_q;
  logic [7:0] result;
  logic [7:0] raw_lim;
  logic irq_meta_q;
  logic irq_q;
  logic dec_meta_q;
  logic dec_q;
  prxcfg_seq_t seq_q;
  prxcfg_seq_t seq_d;
  logic [3:0] diode_en;

  // Sign/magnitude magnitude of an offset, shared by both pairs
  function automatic logic [6:0] sm_mag(input logic [7:0] v);
    sm_mag = v[6:0];
  endfunction

  // Offset registers; the top bit only carries the sign
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      offset_ne_q <= RST_OFFSET;
      offset_sw_q <= RST_OFFSET;
    end else if (REQ_I.wr) begin
      if (REQ_I.addr == ADDR_OFFSET_NE) begin
        offset_ne_q <= REQ_I.wdata;
      end else if (REQ_I.addr == ADDR_OFFSET_SW) begin
        offset_sw_q <= REQ_I.wdata;
      end
    end
  end

  // Config register; bits 7:6 are not stored so a careless write is harmless
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      cfg_q <= RST_CFG;
    end else if (REQ_I.wr && REQ_I.addr == ADDR_DIODE_CFG) begin
      cfg_q <= REQ_I.wdata & CFG_WRITE_MASK;
    end
  end

  // A set mask bit removes its diode from the pairs
  assign diode_en[CFG_MASK_NORTH] = !cfg_q[CFG_MASK_NORTH];
  assign diode_en[CFG_MASK_SOUTH] = !cfg_q[CFG_MASK_SOUTH];
  assign diode_en[CFG_MASK_WEST] = !cfg_q[CFG_MASK_WEST];
  assign diode_en[CFG_MASK_EAST] = !cfg_q[CFG_MASK_EAST];

  // Pair wiring toward the analog path, registered for clean timing
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      AFE_O <= '0;
    end else begin
      AFE_O.offset_ne <= {offset_ne_q[7], sm_mag(offset_ne_q)};
      AFE_O.offset_sw <= {offset_sw_q[7], sm_mag(offset_sw_q)};
      AFE_O.diode_en <= diode_en;
      AFE_O.pair_ne_en <= diode_en[CFG_MASK_NORTH] | diode_en[CFG_MASK_EAST];
      AFE_O.pair_sw_en <= diode_en[CFG_MASK_SOUTH] | diode_en[CFG_MASK_WEST];
    end
  end

  // Half signal from a single diode cannot exceed half scale
  assign raw_lim = (HALF_RAW_I && CONV_RAW_I > HALF_SCALE) ? HALF_SCALE
                   : CONV_RAW_I;

  // Result store with optional doubling
  prxcfg_gain u_gain (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .load_i(CONV_DONE_I),
    .raw_i(raw_lim),
    .comp_i(cfg_q[CFG_PAIR_GAIN_COMP]),
    .result_o(result)
  );

  // Valid flag; a new conversion wins over a clearing read
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      valid_q <= 1'b0;
    end else if (CONV_DONE_I) begin
      valid_q <= 1'b1;
    end else if (REQ_I.rd && REQ_I.addr == ADDR_PROX_RESULT) begin
      valid_q <= 1'b0;
    end
  end
  assign PROX_RESULT_VALID_O = valid_q;

  // Read data; unmapped addresses read as zero
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= 8'h00;
    end else if (REQ_I.rd) begin
      if (REQ_I.addr == ADDR_PROX_RESULT) begin
        RDATA_O <= result;
      end else if (REQ_I.addr == ADDR_OFFSET_NE) begin
        RDATA_O <= offset_ne_q;
      end else if (REQ_I.addr == ADDR_OFFSET_SW) begin
        RDATA_O <= offset_sw_q;
      end else if (REQ_I.addr == ADDR_DIODE_CFG) begin
        RDATA_O <= cfg_q;
      end else begin
        RDATA_O <= 8'h00;
      end
    end
  end

  // Interrupt pin and decision strobe come from outside: two flops each
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      irq_meta_q <= 1'b0;
      irq_q <= 1'b0;
      dec_meta_q <= 1'b0;
      dec_q <= 1'b0;
    end else begin
      irq_meta_q <= IRQ_PIN_I;
      irq_q <= irq_meta_q;
      dec_meta_q <= SEQ_AT_DECISION_I;
      dec_q <= dec_meta_q;
    end
  end

  // Sleep decision state
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      SEQ_RUN: begin
        if (dec_q) begin
          seq_d = SEQ_DECIDE;
        end
      end
      SEQ_DECIDE: begin
        if (cfg_q[CFG_SLEEP_AFTER_IRQ] && irq_q) begin
          seq_d = SEQ_SLEEP;
        end else begin
          seq_d = SEQ_RUN;
        end
      end
      SEQ_SLEEP: begin
        if (!irq_q) begin
          seq_d = SEQ_RUN;
        end
      end
      default: seq_d = SEQ_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      seq_q <= SEQ_RUN;
    end else begin
      seq_q <= seq_d;
    end
  end
  assign SLEEP_O = (seq_q == SEQ_SLEEP);

  // Checks
  AST_RESULT_READ: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    REQ_I.rd && REQ_I.addr == ADDR_PROX_RESULT |=> RDATA_O == $past(result))
    else $error("result read data wrong");
  AST_VALID_CLR: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    REQ_I.rd && REQ_I.addr == ADDR_PROX_RESULT && !CONV_DONE_I |=> !valid_q)
    else $error("valid not cleared by read");
  // A conversion in the cycle of a clearing read must still leave valid set
  AST_VALID_SET: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CONV_DONE_I |=> valid_q)
    else $error("valid not set by conversion");
  AST_NE_WRITE: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    REQ_I.wr && REQ_I.addr == ADDR_OFFSET_NE |=> ##1
    AFE_O.offset_ne == $past(REQ_I.wdata, 2))
    else $error("ne offset not applied");
  AST_SW_WRITE: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    REQ_I.wr && REQ_I.addr == ADDR_OFFSET_SW |=>
    offset_sw_q == $past(REQ_I.wdata))
    else $error("sw offset not stored");
  AST_CFG_RSV: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    cfg_q[7:6] == 2'b00)
    else $error("reserved config bits stored");
  AST_HALF: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CONV_DONE_I && HALF_RAW_I && !cfg_q[CFG_PAIR_GAIN_COMP] |=>
    result <= HALF_SCALE)
    else $error("half signal above 127");
  AST_SAT: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CONV_DONE_I && cfg_q[CFG_PAIR_GAIN_COMP] && raw_lim[7] |=>
    result == FULL_SCALE)
    else $error("compensated result not saturated");
  AST_SLEEP: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    seq_q == SEQ_DECIDE && cfg_q[CFG_SLEEP_AFTER_IRQ] && irq_q |=> SLEEP_O)
    else $error("no sleep after interrupt");
  AST_WAKE: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    SLEEP_O && !irq_q |=> !SLEEP_O)
    else $error("no wake after clear");
  AST_MASK: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    cfg_q[CFG_MASK_NORTH] && cfg_q[CFG_MASK_EAST] |=> !AFE_O.pair_ne_en)
    else $error("masked pair still enabled");
  AST_MASK_SW: assert property (
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    cfg_q[CFG_MASK_SOUTH] && cfg_q[CFG_MASK_WEST] |=> !AFE_O.pair_sw_en)
    else $error("masked south west pair still enabled");
endmodule // prxcfg_top

// >>> verification/prxcfg_host.sv
`timescale 1ns/1ps
// Host on the register port: one-edge pulses, answer taken after it lands
module prxcfg_host import prxcfg_pkg::*; (
  // Clock and read data
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  // Request to the block
  output prxcfg_req_t req_o
);
  initial req_o = '0;
  // Idle request is all zero so a stale address never reads as a request
  task automatic access(input logic rd, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    req_o <= '{rd: rd, wr: !rd, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '0;
    #1 q = rdata_i;
  endtask
  // Config byte as a careful host builds it
  function automatic logic [7:0] cfg_val(input logic [3:0] m, input logic s);
    logic comp;
    comp = m inside {4'h7, 4'hb, 4'he, 4'hd, 4'h6, 4'h9};
    return {2'b00, comp, s, m};
  endfunction
endmodule // prxcfg_host

// >>> verification/tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("unexpected %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb;
  import prxcfg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic done = 1'b0;
  logic [7:0] raw = 8'h00;
  logic half = 1'b0;
  logic decide = 1'b0;
  logic irq = 1'b0;
  logic sleep, valid;
  logic [7:0] rdata, q;
  logic [3:0] mm;
  prxcfg_req_t req;
  prxcfg_afe_t afe;
  int fail_count = 0;
  int cmp_count = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  prxcfg_host host (.clk_i(clk), .rdata_i(rdata), .req_o(req));
  prxcfg_top dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .REQ_I(req),
    .RDATA_O(rdata), .CONV_DONE_I(done), .CONV_RAW_I(raw),
    .HALF_RAW_I(half), .SEQ_AT_DECISION_I(decide), .IRQ_PIN_I(irq),
    .SLEEP_O(sleep), .AFE_O(afe), .PROX_RESULT_VALID_O(valid));
  // Single exit point for the run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Register access wrappers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b0, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.access(1'b1, a, 8'h00, q);
    `CHK("read data", e, q)
  endtask
  // One conversion, then a result read that must drop the valid flag
  task automatic convert(input logic c, input logic h, input logic [7:0] r,
      input logic [7:0] e);
    wr(ADDR_DIODE_CFG, {2'b00, c, 5'h00});
    @(posedge clk);
    done <= 1'b1;
    raw <= r;
    half <= h;
    @(posedge clk);
    done <= 1'b0;
    #1 `CHK("valid set", 1'b1, valid)
    rd_chk(ADDR_PROX_RESULT, e);
    `CHK("valid clear", 1'b0, valid)
  endtask
  // Bounded wait: the sequencer path has two sync flops plus a decide step
  task automatic wait_sleep(input logic e);
    int n;
    n = 0;
    while (sleep !== e && n < 12) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("sleep", e, sleep)
    // A level still wrong after the bound is already counted; stop here
    if (sleep !== e) complete_run();
  endtask
  // Decision pulse with the interrupt pin held high
  task automatic sleep_try(input logic sleep_after_irq);
    wr(ADDR_DIODE_CFG, {3'b000, sleep_after_irq, 4'h0});
    @(posedge clk);
    irq <= 1'b1;
    repeat (2) @(posedge clk);
    decide <= 1'b1;
    @(posedge clk);
    decide <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ADDR_OFFSET_NE, RST_OFFSET);
    rd_chk(ADDR_OFFSET_SW, RST_OFFSET);
    rd_chk(ADDR_DIODE_CFG, RST_CFG);
    rd_chk(ADDR_PROX_RESULT, RST_RESULT);
    wr(ADDR_OFFSET_NE, 8'h81);
    wr(ADDR_OFFSET_SW, 8'h7f);
    wr(ADDR_PROX_RESULT, 8'h5a);
    rd_chk(ADDR_OFFSET_NE, 8'h81);
    rd_chk(ADDR_OFFSET_SW, 8'h7f);
    rd_chk(ADDR_PROX_RESULT, RST_RESULT);
    `CHK("afe ne", 8'h81, afe.offset_ne)
    `CHK("afe sw", 8'h7f, afe.offset_sw)
    rd_chk(8'h9b, 8'h00);
    wr(ADDR_DIODE_CFG, 8'hff);
    rd_chk(ADDR_DIODE_CFG, CFG_WRITE_MASK);
    // Every mask pattern, with compensation as a careful host sets it
    for (int m = 0; m < 16; m++) begin
      mm = 4'(m);
      wr(ADDR_DIODE_CFG, host.cfg_val(mm, 1'b0));
      rd_chk(ADDR_DIODE_CFG, host.cfg_val(mm, 1'b0));
      `CHK("diodes", ~mm, afe.diode_en)
      `CHK("pair ne", ~(mm[3] & mm[0]), afe.pair_ne_en)
      `CHK("pair sw", ~(mm[2] & mm[1]), afe.pair_sw_en)
    end
    convert(1'b0, 1'b0, 8'hc8, 8'hc8);
    convert(1'b0, 1'b1, 8'hc8, HALF_SCALE);
    convert(1'b1, 1'b1, 8'h7f, 8'hfe);
    convert(1'b1, 1'b0, 8'h80, FULL_SCALE);
    sleep_try(1'b1);
    wait_sleep(1'b1);
    // The host clears the interrupt; drive it on an edge like every input
    @(posedge clk);
    irq <= 1'b0;
    wait_sleep(1'b0);
    sleep_try(1'b0);
    repeat (8) @(posedge clk);
    #1 `CHK("no sleep", 1'b0, sleep)
    @(posedge clk);
    irq <= 1'b0;
    complete_run();
  end
endmodule // tb
